// ===== src/sdram_wr_pkg.sv
// shared constants for the sdram write/precharge command block
package sdram_wr_pkg;
   // command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACTIVE = 4'h3;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_BURST_TERM = 4'h6;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
   // address bit carrying auto precharge / all-bank select
   localparam int AP_BIT = 10;
   // mode word field positions
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_CL_LSB = 4;
   localparam int MODE_WB_BIT = 9;
   // burst length code for continuous page
   localparam logic [2:0] BL_PAGE = 3'h7;
   // reset values of the mode word fields
   localparam logic [2:0] BL_RESET = 3'h0;
   localparam logic [2:0] CL_RESET = 3'h2;
   localparam logic WB_RESET = 1'b0;
   // clock period and timing figures in picoseconds
   localparam int CLK_PERIOD_PS = 5000;
   localparam int WRITE_RECOVERY_PS = 12000;
   localparam int PRECHARGE_PERIOD_PS = 18000;
   // write recovery: at least one whole clock plus the time, rounded up
   localparam int WR_CYCLES = 1 + (WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RP_CYCLES = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 4;
   localparam int CL_MAX = 3;
endpackage

// ===== src/bank_tracker.sv
// one bank: open/idle state, pending auto precharge, recovery and precharge timers
`timescale 1ns/1ps
`default_nettype none
module bank_tracker (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_activate,
   input wire logic i_precharge_now,
   input wire logic i_ap_arm,
   input wire logic i_ap_start_rec,
   input wire logic i_ap_start_now,
   output logic o_open,
   output logic o_busy
);
   typedef enum {BANK_IDLE, BANK_OPEN, BANK_RECOVER, BANK_PRECHARGE} bank_state_t;
   bank_state_t state_r;
   logic [sdram_wr_pkg::CNT_W-1:0] cnt_r;
   logic ap_pending_r;

   // pending auto precharge flag, consumed when recovery or precharge starts
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ap_pending_r <= 1'b0;
      end else if (i_ap_arm && !i_ap_start_rec) begin
         ap_pending_r <= 1'b1;
      end else if (i_ap_start_rec || i_ap_start_now || i_precharge_now) begin
         ap_pending_r <= 1'b0;
      end
   end

   // bank released after the precharge count expires; recovery comes first only on a write auto precharge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_r <= BANK_IDLE;
         cnt_r <= '0;
      end else begin
         case (state_r)
            BANK_IDLE: begin
               if (i_activate) begin
                  state_r <= BANK_OPEN;
               end
            end
            BANK_OPEN: begin
               if (i_precharge_now || (ap_pending_r && i_ap_start_now)) begin
                  state_r <= BANK_PRECHARGE;
                  cnt_r <= sdram_wr_pkg::CNT_W'(sdram_wr_pkg::RP_CYCLES - 1);
               end else if ((ap_pending_r || i_ap_arm) && i_ap_start_rec) begin
                  state_r <= BANK_RECOVER;
                  cnt_r <= sdram_wr_pkg::CNT_W'(sdram_wr_pkg::WR_CYCLES - 1);
               end
            end
            BANK_RECOVER: begin
               if (cnt_r == '0) begin
                  state_r <= BANK_PRECHARGE;
                  cnt_r <= sdram_wr_pkg::CNT_W'(sdram_wr_pkg::RP_CYCLES - 1);
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            BANK_PRECHARGE: begin
               if (cnt_r == '0) begin
                  state_r <= BANK_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            default: state_r <= BANK_IDLE;
         endcase
      end
   end

   assign o_open = (state_r == BANK_OPEN);
   assign o_busy = (state_r == BANK_RECOVER) || (state_r == BANK_PRECHARGE);
endmodule
`default_nettype wire

// ===== src/col_counter.sv
// burst column counter: length check and page wrap
`timescale 1ns/1ps
`default_nettype none
module col_counter #(
   parameter int COL_W = 9
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [COL_W-1:0] i_start_col,
   input wire logic [2:0] i_bl_code,
   input wire logic i_single,
   input wire logic i_advance,
   input wire logic i_stop,
   output logic [COL_W-1:0] o_col,
   output logic o_active,
   output logic o_last
);
   logic [COL_W-1:0] col_r;
   logic [COL_W-1:0] left_r;
   logic page_r;
   logic active_r;

   // beats left after the one in hand; page mode never counts down
   function automatic logic [COL_W-1:0] beats_after_first(input logic [2:0] code,
                                                         input logic single);
      if (single || code == 3'h0) begin
         beats_after_first = '0;
      end else begin
         beats_after_first = COL_W'((1 << code) - 1);
      end
   endfunction

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         col_r <= '0;
         left_r <= '0;
         page_r <= 1'b0;
         active_r <= 1'b0;
      end else if (i_load) begin
         // the write edge stores its own beat, so the counter holds the next column
         col_r <= i_start_col + 1'b1;
         page_r <= (i_bl_code == sdram_wr_pkg::BL_PAGE);
         left_r <= beats_after_first(i_bl_code, i_single);
         active_r <= beats_after_first(i_bl_code, i_single) != '0;
      end else if (i_stop) begin
         active_r <= 1'b0;
      end else if (active_r && i_advance) begin
         col_r <= col_r + 1'b1; // wraps through zero by overflow
         if (!page_r) begin
            left_r <= left_r - 1'b1;
            if (left_r == COL_W'(1)) begin
               active_r <= 1'b0;
            end
         end
      end
   end

   assign o_col = col_r;
   assign o_active = active_r;
   assign o_last = active_r && !page_r && (left_r == COL_W'(1));
endmodule
`default_nettype wire

// ===== src/sdram_write_precharge_ctrl.sv
// sdram device command core for write bursts, precharge and auto precharge
// How it works
// - each write to an open bank starts its burst at the bank and column given with it
// - first data word taken with the write, then one per following edge
// - after a fixed burst ends, data pins stay released and input is dropped
// - page write bursts run until ended, wrapping to column zero
// - a new write may come any cycle and replaces the running burst
// - back-to-back writes at full rate to same or other banks
// - a read ends a write burst; data on and after it is ignored
// - auto precharge recovery is one whole clock plus write recovery time
// - burst terminate ends a write; its own edge data is dropped
// - write burst mode bit set makes every write a single column unless burst length is page
// - precharge closes one bank, or all when the address flag is high
// - auto precharge closes the bank at burst end, not in page mode
// - single writes with page length keep page mode and no auto precharge
// - auto precharge is chosen per command, never remembered
// - auto precharge starts at earliest point then runs the precharge period
// - write to another bank cuts an auto precharge read at registration
// - access to another bank cuts auto precharge write; recovery then precharge
`timescale 1ns/1ps
`default_nettype none
module sdram_write_precharge_ctrl #(
   parameter int COL_W = 9,
   parameter int DQ_W = 16,
   parameter int ADDR_W = 13
) (
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic I_CS_N,
   input wire logic I_RAS_N,
   input wire logic I_CAS_N,
   input wire logic I_WE_N,
   input wire logic [1:0] I_BA,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DQ_W-1:0] I_DQ,
   input wire logic I_DQM,
   output logic [DQ_W-1:0] O_DQ,
   output logic O_DQ_OE,
   output logic O_WR_EN,
   output logic [1:0] O_WR_BANK,
   output logic [COL_W-1:0] O_WR_COL,
   output logic [DQ_W-1:0] O_WR_DATA,
   output logic O_READ_START,
   output logic [1:0] O_READ_BANK,
   output logic [COL_W-1:0] O_READ_COL,
   output logic [3:0] O_BANK_OPEN,
   output logic [3:0] O_BANK_BUSY,
   output logic O_WRITE_ACTIVE
);
   // two-stage input sync; stage one feeds only stage two
   logic [3:0] cmd_s1;
   logic [3:0] cmd_s2;
   logic [1:0] ba_s1;
   logic [1:0] ba_s2;
   logic [ADDR_W-1:0] addr_s1;
   logic [ADDR_W-1:0] addr_s2;
   logic [DQ_W-1:0] dq_s1;
   logic [DQ_W-1:0] dq_s2;
   logic dqm_s1;
   logic dqm_s2;

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         cmd_s1 <= sdram_wr_pkg::CMD_NOP;
         cmd_s2 <= sdram_wr_pkg::CMD_NOP;
         ba_s1 <= '0;
         ba_s2 <= '0;
         addr_s1 <= '0;
         addr_s2 <= '0;
         dq_s1 <= '0;
         dq_s2 <= '0;
         dqm_s1 <= 1'b1;
         dqm_s2 <= 1'b1;
      end else begin
         cmd_s1 <= {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N};
         cmd_s2 <= cmd_s1;
         ba_s1 <= I_BA;
         ba_s2 <= ba_s1;
         addr_s1 <= I_ADDR;
         addr_s2 <= addr_s1;
         dq_s1 <= I_DQ;
         dq_s2 <= dq_s1;
         dqm_s1 <= I_DQM;
         dqm_s2 <= dqm_s1;
      end
   end

   // command decode; command, address and data travel aligned through the sync
   logic is_write;
   logic is_read;
   logic is_pre;
   logic is_act;
   logic is_bst;
   logic is_mode;
   logic ap_flag;
   assign is_write = (cmd_s2 == sdram_wr_pkg::CMD_WRITE);
   assign is_read = (cmd_s2 == sdram_wr_pkg::CMD_READ);
   assign is_pre = (cmd_s2 == sdram_wr_pkg::CMD_PRECHARGE);
   assign is_act = (cmd_s2 == sdram_wr_pkg::CMD_ACTIVE);
   assign is_bst = (cmd_s2 == sdram_wr_pkg::CMD_BURST_TERM);
   assign is_mode = (cmd_s2 == sdram_wr_pkg::CMD_LOAD_MODE);
   assign ap_flag = addr_s2[sdram_wr_pkg::AP_BIT];

   // mode word: burst length, cas latency, write burst mode bit
   logic [2:0] burst_length_r;
   logic [2:0] cas_latency_r;
   logic write_burst_mode_bit_r;
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         burst_length_r <= sdram_wr_pkg::BL_RESET;
         cas_latency_r <= sdram_wr_pkg::CL_RESET;
         write_burst_mode_bit_r <= sdram_wr_pkg::WB_RESET;
      end else if (is_mode) begin
         burst_length_r <= addr_s2[sdram_wr_pkg::MODE_BL_LSB +: 3];
         cas_latency_r <= addr_s2[sdram_wr_pkg::MODE_CL_LSB +: 3];
         write_burst_mode_bit_r <= addr_s2[sdram_wr_pkg::MODE_WB_BIT];
      end
   end

   logic page_mode;
   assign page_mode = (burst_length_r == sdram_wr_pkg::BL_PAGE);

   // running write burst context
   logic wr_active;
   logic wr_last;
   logic [COL_W-1:0] wr_col;
   logic [1:0] wr_bank_r;
   logic wr_ap_r;
   logic new_write_ok;
   logic bank_open_vec [4];
   logic bank_busy_vec [4];

   assign new_write_ok = is_write && bank_open_vec[ba_s2]; // idle bank refuses access

   // the write counter; a read, terminate, or precharge of its bank or all banks cuts it short
   col_counter #(
      .COL_W(COL_W)
   ) u_wr_col (
      .i_clk(I_CLOCK),
      .i_rst_n(I_RST_N),
      .i_load(new_write_ok),
      .i_start_col(addr_s2[COL_W-1:0]),
      .i_bl_code(burst_length_r),
      .i_single(write_burst_mode_bit_r && !page_mode),
      .i_advance(1'b1),
      .i_stop(is_read || is_bst || (is_pre && (ap_flag || ba_s2 == wr_bank_r))),
      .o_col(wr_col),
      .o_active(wr_active),
      .o_last(wr_last)
   );

   // a beat is stored on the write edge itself or while the burst runs
   logic beat_cmd;
   logic beat_run;
   assign beat_cmd = new_write_ok;
   assign beat_run = wr_active && !is_write && !is_read && !is_bst && !is_pre;

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         O_WR_EN <= 1'b0;
         O_WR_BANK <= '0;
         O_WR_COL <= '0;
         O_WR_DATA <= '0;
      end else begin
         // masked beats still advance the column but store nothing
         O_WR_EN <= (beat_cmd || beat_run) && !dqm_s2;
         O_WR_BANK <= beat_cmd ? ba_s2 : wr_bank_r;
         O_WR_COL <= beat_cmd ? addr_s2[COL_W-1:0] : wr_col;
         O_WR_DATA <= dq_s2;
      end
   end

   // per-command auto precharge capture; never carried over
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         wr_bank_r <= '0;
         wr_ap_r <= 1'b0;
      end else if (new_write_ok) begin
         wr_bank_r <= ba_s2;
         wr_ap_r <= ap_flag && !page_mode;
      end
   end

   // read tracking for auto precharge on read bursts
   logic rd_active_r;
   logic [1:0] rd_bank_r;
   logic rd_ap_r;
   logic [sdram_wr_pkg::CNT_W-1:0] rd_left_r;
   logic rd_ok;
   assign rd_ok = is_read && bank_open_vec[ba_s2];

   function automatic logic [sdram_wr_pkg::CNT_W-1:0] read_beats(input logic [2:0] code);
      read_beats = (code == 3'h0) ? '0 : sdram_wr_pkg::CNT_W'((1 << code) - 1);
   endfunction

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         rd_active_r <= 1'b0;
         rd_bank_r <= '0;
         rd_ap_r <= 1'b0;
         rd_left_r <= '0;
      end else if (rd_ok) begin
         rd_active_r <= 1'b1;
         rd_bank_r <= ba_s2;
         rd_ap_r <= ap_flag && !page_mode;
         rd_left_r <= page_mode ? '0 : read_beats(burst_length_r); // reads keep length
      end else if (new_write_ok || is_bst || is_pre) begin
         rd_active_r <= 1'b0;
      end else if (rd_active_r && !page_mode) begin
         if (rd_left_r == '0) begin
            rd_active_r <= 1'b0;
         end else begin
            rd_left_r <= rd_left_r - 1'b1;
         end
      end
   end

   // read launch strobe toward the array; output path not covered here
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         O_READ_START <= 1'b0;
         O_READ_BANK <= '0;
         O_READ_COL <= '0;
      end else begin
         O_READ_START <= rd_ok;
         O_READ_BANK <= ba_s2;
         O_READ_COL <= addr_s2[COL_W-1:0];
      end
   end

   // auto precharge triggers per bank
   logic [3:0] ap_arm;
   logic [3:0] ap_rec;
   logic [3:0] ap_now;
   logic [3:0] pre_now;
   logic wr_natural_end;
   logic rd_natural_end;
   logic wr_cut_other;
   logic rd_cut_other;
   assign wr_natural_end = wr_last && beat_run;
   assign rd_natural_end = rd_active_r && !page_mode && rd_left_r == '0 && !rd_ok;
   assign wr_cut_other = wr_active && (is_read || is_write) && ba_s2 != wr_bank_r;
   assign rd_cut_other = rd_active_r && (is_read || is_write) && ba_s2 != rd_bank_r;

   always_comb begin
      ap_arm = '0;
      ap_rec = '0;
      ap_now = '0;
      pre_now = '0;
      if (new_write_ok && ap_flag && !page_mode) begin
         ap_arm[ba_s2] = 1'b1;
      end
      if (rd_ok && ap_flag && !page_mode) begin
         ap_arm[ba_s2] = 1'b1;
      end
      // write with auto precharge: recovery then precharge
      if (wr_ap_r && (wr_natural_end || wr_cut_other || (wr_active && beat_cmd == 1'b0
            && wr_last && !beat_run))) begin
         ap_rec[wr_bank_r] = 1'b1;
      end
      if (new_write_ok && ap_flag && !page_mode && (write_burst_mode_bit_r
            || burst_length_r == 3'h0)) begin
         ap_rec[ba_s2] = 1'b1;
      end
      // read with auto precharge: precharge starts at once
      if (rd_ap_r && (rd_natural_end || rd_cut_other)) begin
         ap_now[rd_bank_r] = 1'b1;
      end
      if (is_pre) begin
         if (ap_flag) begin
            pre_now = 4'hf;
         end else begin
            pre_now[ba_s2] = 1'b1;
         end
      end
   end

   // four bank trackers
   logic [3:0] open_bits;
   logic [3:0] busy_bits;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_bank
         bank_tracker u_bank (
            .i_clk(I_CLOCK),
            .i_rst_n(I_RST_N),
            .i_activate(is_act && ba_s2 == 2'(gi)),
            .i_precharge_now(pre_now[gi]),
            .i_ap_arm(ap_arm[gi]),
            .i_ap_start_rec(ap_rec[gi]),
            .i_ap_start_now(ap_now[gi]),
            .o_open(open_bits[gi]),
            .o_busy(busy_bits[gi])
         );
         assign bank_open_vec[gi] = open_bits[gi];
         assign bank_busy_vec[gi] = busy_bits[gi];
      end
   endgenerate

   // status and data pin outputs; writes never drive the pins
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         O_BANK_OPEN <= '0;
         O_BANK_BUSY <= '0;
         O_WRITE_ACTIVE <= 1'b0;
         O_DQ <= '0;
         O_DQ_OE <= 1'b0;
      end else begin
         O_BANK_OPEN <= open_bits;
         O_BANK_BUSY <= busy_bits;
         O_WRITE_ACTIVE <= wr_active;
         O_DQ <= '0;
         O_DQ_OE <= 1'b0; // read data path lives elsewhere
      end
   end
endmodule
`default_nettype wire

// ===== verification/sdram_wp_checker.sv
// assertion checker on the ports of the sdram write/precharge block
`timescale 1ns/1ps
`default_nettype none
module sdram_wp_checker #(
   parameter int COL_W = 9,
   parameter int DQ_W = 16,
   parameter int ADDR_W = 13
) (
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic I_CS_N,
   input wire logic I_RAS_N,
   input wire logic I_CAS_N,
   input wire logic I_WE_N,
   input wire logic [1:0] I_BA,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DQ_W-1:0] I_DQ,
   input wire logic I_DQM,
   input wire logic O_DQ_OE,
   input wire logic O_WR_EN,
   input wire logic [1:0] O_WR_BANK,
   input wire logic [COL_W-1:0] O_WR_COL,
   input wire logic [DQ_W-1:0] O_WR_DATA,
   input wire logic O_READ_START,
   input wire logic [3:0] O_BANK_OPEN,
   input wire logic [3:0] O_BANK_BUSY
);
   logic [3:0] cmd;
   // command word in pin order
   assign cmd = {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N};
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RST_N);
   sequence s_rd;
      cmd == sdram_wr_pkg::CMD_READ;
   endsequence
   sequence s_bst;
      cmd == sdram_wr_pkg::CMD_BURST_TERM;
   endsequence
   sequence s_pre_all;
      cmd == sdram_wr_pkg::CMD_PRECHARGE && I_ADDR[sdram_wr_pkg::AP_BIT];
   endsequence
   // the beat on the pins three sampled edges back would be the store now
   sequence s_no_store;
      ##3 !O_WR_EN;
   endsequence
   property p_dq_idle;
      !O_DQ_OE;
   endproperty
   property p_beat_data;
      O_WR_EN |-> !$past(I_DQM, 3) && O_WR_DATA == $past(I_DQ, 3);
   endproperty
   property p_first_col;
      O_WR_EN && $past(cmd, 3) == sdram_wr_pkg::CMD_WRITE
         |-> O_WR_COL == $past(I_ADDR[COL_W-1:0], 3) && O_WR_BANK == $past(I_BA, 3);
   endproperty
   // column steps by one and wraps at the page end
   property p_col_step;
      O_WR_EN && $past(O_WR_EN) && $past(cmd, 3) != sdram_wr_pkg::CMD_WRITE
         |-> O_WR_COL == $past(O_WR_COL) + 1'b1 && O_WR_BANK == $past(O_WR_BANK);
   endproperty
   property p_read_cut;
      s_rd |-> s_no_store;
   endproperty
   property p_bst_cut;
      s_bst |-> s_no_store;
   endproperty
   property p_pre_all;
      s_pre_all |-> ##[1:6] O_BANK_OPEN == 4'h0;
   endproperty
   property p_reset_out;
      $rose(I_RST_N) |-> !O_WR_EN && !O_READ_START && O_BANK_OPEN == 4'h0 && O_BANK_BUSY == 4'h0;
   endproperty
   a_dq_idle: assert property (p_dq_idle) else $error("data pins driven");
   a_beat_data: assert property (p_beat_data) else $error("stored word wrong");
   a_first_col: assert property (p_first_col) else $error("burst start wrong");
   a_col_step: assert property (p_col_step) else $error("column step wrong");
   a_read_cut: assert property (p_read_cut) else $error("store on read edge");
   a_bst_cut: assert property (p_bst_cut) else $error("store on terminate edge");
   a_pre_all: assert property (p_pre_all) else $error("banks left open");
   a_reset_out: assert property (p_reset_out) else $error("outputs not clear");
endmodule
bind sdram_write_precharge_ctrl sdram_wp_checker #(.COL_W(COL_W), .DQ_W(DQ_W), .ADDR_W(ADDR_W))
   u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_RAS_N(I_RAS_N),
   .I_CAS_N(I_CAS_N), .I_WE_N(I_WE_N), .I_BA(I_BA), .I_ADDR(I_ADDR), .I_DQ(I_DQ),
   .I_DQM(I_DQM), .O_DQ_OE(O_DQ_OE), .O_WR_EN(O_WR_EN), .O_WR_BANK(O_WR_BANK),
   .O_WR_COL(O_WR_COL), .O_WR_DATA(O_WR_DATA), .O_READ_START(O_READ_START),
   .O_BANK_OPEN(O_BANK_OPEN), .O_BANK_BUSY(O_BANK_BUSY));
`default_nettype wire

// ===== verification/sdram_host_model.sv
// memory controller model: commands, address and write data on each edge
`timescale 1ns/1ps
`default_nettype none
module sdram_host_model (
   input wire logic i_clk,
   output logic o_cs_n,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output logic [1:0] o_ba,
   output logic [12:0] o_addr,
   output logic [15:0] o_dq,
   output logic o_dqm
);
   // idle bus at time zero
   initial begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = sdram_wr_pkg::CMD_NOP;
      o_ba = 2'h0;
      o_addr = 13'h0000;
      o_dq = 16'h0000;
      o_dqm = 1'b0;
   end
   // one command per edge; bank, column and data travel with it
   task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a,
         input logic [15:0] d, input logic m);
      @(posedge i_clk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= c;
      o_ba <= ba;
      o_addr <= a;
      o_dq <= d;
      o_dqm <= m;
   endtask
   // released data lines toggle so a stale word never looks fresh
   task automatic nop(input int n);
      repeat (n) cmd(sdram_wr_pkg::CMD_NOP, 2'h0, 13'h0000, ~o_dq, 1'b0);
   endtask
   task automatic wr(input logic [1:0] ba, input logic [8:0] col, input logic ap,
         input logic [15:0] d);
      cmd(sdram_wr_pkg::CMD_WRITE, ba, {2'h0, ap, 1'b0, col}, d, 1'b0);
   endtask
   task automatic beat(input logic [15:0] d, input logic m);
      cmd(sdram_wr_pkg::CMD_NOP, 2'h0, 13'h0000, d, m);
   endtask
   task automatic act(input logic [1:0] ba);
      cmd(sdram_wr_pkg::CMD_ACTIVE, ba, 13'h0000, 16'h0000, 1'b0);
      nop(3);
   endtask
   task automatic mode(input logic [2:0] bl, input logic wb);
      cmd(sdram_wr_pkg::CMD_LOAD_MODE, 2'h0, {3'h0, wb, 2'h0, 3'h2, 1'b0, bl}, 16'h0000,
         1'b0);
      nop(3);
   endtask
   // recovery beats masked so a running page burst stores nothing more
   task automatic pre(input logic [1:0] ba, input logic all);
      repeat (sdram_wr_pkg::WR_CYCLES) beat(~o_dq, 1'b1);
      cmd(sdram_wr_pkg::CMD_PRECHARGE, ba, {2'h0, all, 10'h000}, ~o_dq, 1'b1);
      nop(sdram_wr_pkg::RP_CYCLES + 2);
   endtask
endmodule
`default_nettype wire

// ===== verification/sdram_write_precharge_ctrl_tb.sv
// self-checking bench for the sdram write/precharge command block
`timescale 1ns/1ps
`default_nettype none
module sdram_write_precharge_ctrl_tb;
   logic clk;
   logic rst_n;
   wire logic cs_n, ras_n, cas_n, we_n, dqm;
   wire logic [1:0] ba;
   wire logic [12:0] addr;
   wire logic [15:0] dq;
   logic wr_en, rd_start, wr_act, dq_oe;
   logic [1:0] wr_bank, rd_bank;
   logic [8:0] wr_col, rd_col;
   logic [15:0] wr_data, dq_out;
   logic [10:0] rd_seen;
   logic [3:0] bank_open, bank_busy;
   int n_fail = 0;
   int check_count = 0;
   int rd_count = 0;
   logic [26:0] got_q[$];
   logic [26:0] exp_q[$];
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   sdram_host_model u_host (.i_clk(clk), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
      .o_we_n(we_n), .o_ba(ba), .o_addr(addr), .o_dq(dq), .o_dqm(dqm));
   sdram_write_precharge_ctrl uut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n),
      .I_RAS_N(ras_n), .I_CAS_N(cas_n), .I_WE_N(we_n), .I_BA(ba), .I_ADDR(addr),
      .I_DQ(dq), .I_DQM(dqm), .O_DQ(dq_out), .O_DQ_OE(dq_oe), .O_WR_EN(wr_en),
      .O_WR_BANK(wr_bank), .O_WR_COL(wr_col), .O_WR_DATA(wr_data), .O_READ_START(rd_start),
      .O_READ_BANK(rd_bank), .O_READ_COL(rd_col), .O_BANK_OPEN(bank_open),
      .O_BANK_BUSY(bank_busy), .O_WRITE_ACTIVE(wr_act));
   // log each stored beat and read start mid-cycle, while it stands
   always @(negedge clk) begin
      if (wr_en === 1'b1)
         got_q.push_back({wr_bank, wr_col, wr_data});
      if (rd_start === 1'b1) begin
         rd_count++;
         rd_seen = {rd_bank, rd_col};
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ex(input logic [1:0] b, input logic [8:0] c, input logic [15:0] d);
      exp_q.push_back({b, c, d});
   endtask
   // drain the pipe, then compare stored beats with the expected list
   task automatic settle();
      u_host.nop(8);
      @(negedge clk);
      check(got_q.size(), exp_q.size());
      foreach (exp_q[i])
         if (i < got_q.size())
            check({5'h00, got_q[i]}, {5'h00, exp_q[i]});
      got_q.delete();
      exp_q.delete();
   endtask
   task automatic test_done();
      if (n_fail == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // whole sequence needs a few hundred cycles
   initial begin
      #100000;
      n_fail++;
      test_done();
   end
   initial begin
      int busy_n;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      u_host.nop(3);
      // burst of two; words past its end are dropped
      u_host.mode(3'h1, 1'b0);
      u_host.act(2'h0);
      u_host.act(2'h1);
      u_host.wr(2'h0, 9'h004, 1'b0, 16'ha000);
      u_host.beat(16'ha001, 1'b0);
      u_host.beat(16'ha002, 1'b0);
      ex(2'h0, 9'h004, 16'ha000);
      ex(2'h0, 9'h005, 16'ha001);
      settle();
      check(wr_act, 1'b0);
      // back-to-back writes, second to another bank cuts the first
      u_host.mode(3'h2, 1'b0);
      u_host.wr(2'h0, 9'h008, 1'b0, 16'hb000);
      u_host.wr(2'h1, 9'h010, 1'b0, 16'hb001);
      u_host.beat(16'hb002, 1'b0);
      u_host.beat(16'hb003, 1'b0);
      u_host.beat(16'hb004, 1'b0);
      u_host.beat(16'hb005, 1'b0);
      ex(2'h0, 9'h008, 16'hb000);
      ex(2'h1, 9'h010, 16'hb001);
      ex(2'h1, 9'h011, 16'hb002);
      ex(2'h1, 9'h012, 16'hb003);
      ex(2'h1, 9'h013, 16'hb004);
      settle();
      // read in mid burst: its own edge and later data are dropped
      u_host.wr(2'h0, 9'h020, 1'b0, 16'hc000);
      u_host.beat(16'hc001, 1'b0);
      u_host.cmd(sdram_wr_pkg::CMD_READ, 2'h1, 13'h0028, 16'hc002, 1'b0);
      u_host.beat(16'hc003, 1'b1);
      ex(2'h0, 9'h020, 16'hc000);
      ex(2'h0, 9'h021, 16'hc001);
      settle();
      check(rd_count, 1);
      check(rd_seen, {2'h1, 9'h028});
      // single-location writes despite a burst of four
      u_host.mode(3'h2, 1'b1);
      u_host.wr(2'h1, 9'h040, 1'b0, 16'hd000);
      u_host.beat(16'hd001, 1'b0);
      ex(2'h1, 9'h040, 16'hd000);
      settle();
      // page length wins over single writes; wrap, masked beat, terminate
      u_host.mode(sdram_wr_pkg::BL_PAGE, 1'b1);
      u_host.wr(2'h0, 9'h1fe, 1'b1, 16'he000);
      u_host.beat(16'he001, 1'b0);
      u_host.beat(16'he002, 1'b1);
      u_host.beat(16'he003, 1'b0);
      u_host.cmd(sdram_wr_pkg::CMD_BURST_TERM, 2'h0, 13'h0000, 16'he004, 1'b0);
      ex(2'h0, 9'h1fe, 16'he000);
      ex(2'h0, 9'h1ff, 16'he001);
      ex(2'h0, 9'h001, 16'he003);
      settle();
      check(wr_act, 1'b0);
      check(bank_open[0], 1'b1);
      // precharge ends a page burst on one bank only
      u_host.act(2'h3);
      u_host.wr(2'h3, 9'h000, 1'b0, 16'hf000);
      u_host.beat(16'hf001, 1'b0);
      u_host.pre(2'h3, 1'b0);
      ex(2'h3, 9'h000, 16'hf000);
      ex(2'h3, 9'h001, 16'hf001);
      settle();
      check(bank_open, 4'h3);
      // auto precharge: recovery then precharge, bank idle afterwards
      u_host.mode(3'h1, 1'b0);
      u_host.act(2'h2);
      u_host.wr(2'h2, 9'h00c, 1'b1, 16'h1200);
      u_host.beat(16'h1201, 1'b0);
      busy_n = 0;
      repeat (30) begin
         u_host.nop(1);
         @(negedge clk);
         if (bank_busy[2] === 1'b1)
            busy_n++;
      end
      check(busy_n, sdram_wr_pkg::WR_CYCLES + sdram_wr_pkg::RP_CYCLES);
      check(bank_open[2], 1'b0);
      ex(2'h2, 9'h00c, 16'h1200);
      ex(2'h2, 9'h00d, 16'h1201);
      settle();
      // next write without the flag leaves the bank open
      u_host.act(2'h2);
      u_host.wr(2'h2, 9'h014, 1'b0, 16'h1300);
      u_host.beat(16'h1301, 1'b0);
      ex(2'h2, 9'h014, 16'h1300);
      ex(2'h2, 9'h015, 16'h1301);
      settle();
      check(bank_open[2], 1'b1);
      // precharge all, then a write to an idle bank stores nothing
      u_host.pre(2'h1, 1'b1);
      check(bank_open, 4'h0);
      u_host.wr(2'h0, 9'h005, 1'b0, 16'h2000);
      u_host.beat(16'h2001, 1'b0);
      settle();
      check({dq_oe, dq_out}, 17'h0);
      test_done();
   end
endmodule
`default_nettype wire
